// *** hdl/smm_pkg.sv ***
// Constants for the monitor's serial management slave and its control logic.
// Assumes a 100 MHz core clock; every timing count except STRAP_DELAY derives from that period.
package smm_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TEMP_CONV_NS = 1688000;
  localparam int unsigned VOLT_CONV_NS = 1511000;
  localparam int unsigned RST_PULSE_MS = 20;
  localparam int unsigned CYCLE_PERIOD_MS = 1000;
  // Conversion times are nominal, so they round down; the pulse is a least time and rounds up.
  localparam int unsigned TEMP_CONV_CYC = TEMP_CONV_NS / CLK_PERIOD_NS;
  localparam int unsigned VOLT_CONV_CYC = VOLT_CONV_NS / CLK_PERIOD_NS;
  localparam int unsigned RST_PULSE_CYC = (RST_PULSE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYCLE_PERIOD_CYC = CYCLE_PERIOD_MS * (1000000 / CLK_PERIOD_NS);
  localparam logic [1:0] STRAP_DELAY = 2'h3;

  // ---------------------------------------------------------------------------
  // Serial addressing
  // ---------------------------------------------------------------------------
  localparam logic [5:0] SLAVE_ADDR_HI = 6'h16;
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] REG_CONFIG = 8'h40;
  localparam logic [7:0] REG_VOLT_CODE = 8'h47;
  localparam logic [7:0] REG_SPECIAL = 8'h4F;
  localparam logic [7:0] PTR_RESET = 8'h40;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] SPECIAL_RESET = 8'h00;
  localparam logic VOLT_RST_EN_RESET = 1'b0;

  localparam int CFG_START_BIT = 0;
  localparam int CFG_ALERT_EN_BIT = 1;
  localparam int CFG_RST_PULSE_BIT = 4;
  localparam int CFG_VID4_SEL_BIT = 5;
  localparam int CFG_SOFT_RST_BIT = 7;
  localparam int VC_RST_EN_BIT = 7;
  localparam int SF_CYCLE_MODE_BIT = 1;
  localparam int SF_FAST_AVG_BIT = 5;

  // ---------------------------------------------------------------------------
  // Monitoring sequence
  // ---------------------------------------------------------------------------
  localparam int unsigned NUM_CHAN = 11;
  localparam logic [3:0] CH_REMOTE1 = 4'h0;
  localparam logic [3:0] CH_AMBIENT = 4'h1;
  localparam logic [3:0] CH_12V = 4'h3;
  localparam logic [3:0] CH_REMOTE2 = 4'h8;
  localparam logic [3:0] CH_LAST = 4'hA;
  localparam logic [7:0] AVG_REMOTE_SLOW = 8'h80;
  localparam logic [7:0] AVG_REMOTE_FAST = 8'h10;
  localparam logic [7:0] AVG_OTHER_SLOW = 8'h08;
  localparam logic [7:0] AVG_OTHER_FAST = 8'h01;

endpackage

// *** hdl/smm_slave_ctrl.sv ***
// Serial management slave of the hardware monitor with its control registers,
// monitoring sequencer, reset pulse and alert logic.
// Assumes serial clock, serial data, the shared strap pin and the voltage-code
// pins arrive asynchronously; limit comparison results come from core-clock logic.
`timescale 1ns/1ns

module smm_slave_ctrl import smm_pkg::*; #(
  parameter int unsigned TEMP_CONV_CYCLES = TEMP_CONV_CYC,
  parameter int unsigned VOLT_CONV_CYCLES = VOLT_CONV_CYC,
  parameter int unsigned RST_PULSE_CYCLES = RST_PULSE_CYC,
  parameter int unsigned CYCLE_PERIOD_CYCLES = CYCLE_PERIOD_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Serial link
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Shared strap, reset and alert pin (open drain)
  input wire logic addr_lsb_select_pin_i,
  output logic addr_lsb_select_pin_o,
  output logic addr_lsb_select_pin_oe_o,
  // Processor voltage code pins
  input wire logic [3:0] cpu_volt_code_i,
  // Limit comparator results, one per channel
  input wire logic [NUM_CHAN-1:0] limit_fault_i,
  // Monitor status
  output logic conv_done_o,
  output logic [3:0] conv_chan_o,
  output logic [NUM_CHAN-1:0] int_status_o,
  output logic monitor_busy_o
);

  // A zero count would act as one in the sequencer and the period wait, and would suppress the pulse.
  if (TEMP_CONV_CYCLES < 1 || VOLT_CONV_CYCLES < 1 || RST_PULSE_CYCLES < 1
      || CYCLE_PERIOD_CYCLES < 1) begin : g_bad_timing
    $error("Timing counts must be at least one cycle.");
  end

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic valid_reg(input logic [7:0] a);
    valid_reg = (a == REG_CONFIG) || (a == REG_VOLT_CODE) || (a == REG_SPECIAL);
  endfunction

  function automatic logic [7:0] avg_count(input logic [3:0] ch, input logic fast);
    if (ch == CH_REMOTE1 || ch == CH_REMOTE2) begin
      avg_count = fast ? AVG_REMOTE_FAST : AVG_REMOTE_SLOW;
    end else begin
      avg_count = fast ? AVG_OTHER_FAST : AVG_OTHER_SLOW;
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Input synchronisers and strap capture
  // ---------------------------------------------------------------------------
  logic [1:0] scl_sync_ff, sda_sync_ff, pin_sync_ff;
  logic [3:0] vc_sync1_ff, vc_sync2_ff;
  logic scl_q_ff, sda_q_ff;
  logic [1:0] strap_cnt_ff, nxt_strap_cnt;
  logic strap_done_ff, nxt_strap_done;
  logic strap_ff, nxt_strap;

  always_comb begin
    nxt_strap_cnt = strap_cnt_ff;
    nxt_strap_done = strap_done_ff;
    nxt_strap = strap_ff;
    if (!strap_done_ff) begin
      nxt_strap_cnt = strap_cnt_ff + 2'h1;
      if (strap_cnt_ff == STRAP_DELAY) begin
        nxt_strap_done = 1'b1;
        nxt_strap = pin_sync_ff[1];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      pin_sync_ff <= 2'h3;
      vc_sync1_ff <= 4'h0;
      vc_sync2_ff <= 4'h0;
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      strap_cnt_ff <= 2'h0;
      strap_done_ff <= 1'b0;
      strap_ff <= 1'b0;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_i};
      sda_sync_ff <= {sda_sync_ff[0], sda_i};
      pin_sync_ff <= {pin_sync_ff[0], addr_lsb_select_pin_i};
      vc_sync1_ff <= cpu_volt_code_i;
      vc_sync2_ff <= vc_sync1_ff;
      scl_q_ff <= scl_sync_ff[1];
      sda_q_ff <= sda_sync_ff[1];
      strap_cnt_ff <= nxt_strap_cnt;
      strap_done_ff <= nxt_strap_done;
      strap_ff <= nxt_strap;
    end
  end

  logic scl_s, sda_s, scl_rise, scl_fall, bus_start, bus_stop;
  logic [6:0] my_addr;
  // Edges come from the real line level, so a stretched clock simply delays them.
  assign scl_s = scl_sync_ff[1];
  assign sda_s = sda_sync_ff[1];
  assign scl_rise = scl_s && !scl_q_ff;
  assign scl_fall = !scl_s && scl_q_ff;
  assign bus_start = scl_s && scl_q_ff && sda_q_ff && !sda_s;
  assign bus_stop = scl_s && scl_q_ff && !sda_q_ff && sda_s;
  assign my_addr = {SLAVE_ADDR_HI, strap_ff};

  // ---------------------------------------------------------------------------
  // Serial slave engine
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {L_IDLE, L_ADDR, L_REG, L_DATA, L_DONE, L_TX, L_TXACK, L_WAIT} smm_link_t;

  smm_link_t lst_ff, nxt_lst;
  logic [3:0] bit_cnt_ff, nxt_bit_cnt;
  logic ack_ff, nxt_ack;
  logic drv_ff, nxt_drv;
  logic [7:0] rx_sh_ff, nxt_rx_sh;
  logic [7:0] tx_sh_ff, nxt_tx_sh;
  logic [7:0] ptr_ff, nxt_ptr;
  logic [7:0] wdata_ff, nxt_wdata;
  logic wr_stb_ff, nxt_wr_stb;
  logic ara_stb_ff, nxt_ara_stb;
  logic [7:0] cfg_ff, vc_reg_ff, sf_ff;
  logic alert_ff;
  logic [7:0] rd_data;

  always_comb begin
    unique case (ptr_ff)
      REG_CONFIG: rd_data = cfg_ff;
      REG_VOLT_CODE: rd_data = {vc_reg_ff[7:4], vc_sync2_ff};
      default: rd_data = sf_ff;
    endcase
  end

  always_comb begin
    nxt_lst = lst_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_ack = ack_ff;
    nxt_drv = drv_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_ptr = ptr_ff;
    nxt_wdata = wdata_ff;
    nxt_wr_stb = 1'b0;
    nxt_ara_stb = 1'b0;
    if (!strap_done_ff) begin
      nxt_lst = L_IDLE;
    end else if (bus_stop) begin
      nxt_wr_stb = (lst_ff == L_DONE) && !ack_ff;
      nxt_lst = L_IDLE;
      nxt_drv = 1'b0;
      nxt_ack = 1'b0;
    end else if (bus_start) begin
      // A repeated start also discards any write not yet closed by a stop.
      nxt_lst = L_ADDR;
      nxt_bit_cnt = 4'h0;
      nxt_ack = 1'b0;
      nxt_drv = 1'b0;
    end else if (ack_ff) begin
      if (scl_fall) begin
        nxt_ack = 1'b0;
        nxt_bit_cnt = 4'h0;
        nxt_drv = (lst_ff == L_TX) && !tx_sh_ff[7];
      end
    end else begin
      unique case (lst_ff)
        L_ADDR, L_REG, L_DATA: begin
          if (scl_rise && bit_cnt_ff < BITS_PER_BYTE) begin
            nxt_rx_sh = {rx_sh_ff[6:0], sda_s};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end else if (scl_fall && bit_cnt_ff == BITS_PER_BYTE) begin
            nxt_ack = 1'b1;
            nxt_drv = 1'b1;
            if (lst_ff == L_ADDR) begin
              if (rx_sh_ff[7:1] == my_addr) begin
                nxt_lst = rx_sh_ff[0] ? L_TX : L_REG;
                nxt_tx_sh = rd_data;
              end else if (rx_sh_ff == {ALERT_RESP_ADDR, 1'b1} && alert_ff) begin
                nxt_lst = L_TX;
                nxt_tx_sh = {my_addr, 1'b1};
                nxt_ara_stb = 1'b1;
              end else begin
                nxt_lst = L_WAIT;
                nxt_ack = 1'b0;
                nxt_drv = 1'b0;
              end
            end else if (lst_ff == L_REG) begin
              if (valid_reg(rx_sh_ff)) begin
                nxt_ptr = rx_sh_ff;
                nxt_lst = L_DATA;
              end else begin
                nxt_lst = L_WAIT;
                nxt_ack = 1'b0;
                nxt_drv = 1'b0;
              end
            end else begin
              nxt_wdata = rx_sh_ff;
              nxt_lst = L_DONE;
            end
          end
        end
        L_DONE: begin
          if (scl_fall) begin
            nxt_lst = L_WAIT;
          end
        end
        L_TX: begin
          if (scl_fall) begin
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
            nxt_tx_sh = {tx_sh_ff[6:0], 1'b0};
            if (bit_cnt_ff == BITS_PER_BYTE - 4'h1) begin
              nxt_drv = 1'b0;
              nxt_lst = L_TXACK;
            end else begin
              nxt_drv = !tx_sh_ff[6];
            end
          end
        end
        L_TXACK: begin
          if (scl_rise) begin
            nxt_lst = L_WAIT;
          end
        end
        L_IDLE, L_WAIT: begin
        end
      endcase
    end
  end

  // No bus timeout exists: the engine holds state for as long as the clock stays low.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lst_ff <= L_IDLE;
      bit_cnt_ff <= 4'h0;
      ack_ff <= 1'b0;
      drv_ff <= 1'b0;
      rx_sh_ff <= 8'h00;
      tx_sh_ff <= 8'h00;
      ptr_ff <= PTR_RESET;
      wdata_ff <= 8'h00;
      wr_stb_ff <= 1'b0;
      ara_stb_ff <= 1'b0;
    end else begin
      lst_ff <= nxt_lst;
      bit_cnt_ff <= nxt_bit_cnt;
      ack_ff <= nxt_ack;
      drv_ff <= nxt_drv;
      rx_sh_ff <= nxt_rx_sh;
      tx_sh_ff <= nxt_tx_sh;
      ptr_ff <= nxt_ptr;
      wdata_ff <= nxt_wdata;
      wr_stb_ff <= nxt_wr_stb;
      ara_stb_ff <= nxt_ara_stb;
    end
  end

  // ---------------------------------------------------------------------------
  // Registers, monitoring sequencer, reset pulse and alert
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {M_IDLE, M_CONV, M_WAIT} smm_mon_t;

  smm_mon_t mst_ff, nxt_mst;
  logic [7:0] nxt_cfg, nxt_vc_reg, nxt_sf;
  logic [3:0] ch_ff, nxt_ch;
  logic [7:0] avg_ff, nxt_avg;
  logic [31:0] conv_tmr_ff, nxt_conv_tmr;
  logic [31:0] per_tmr_ff, nxt_per_tmr;
  logic [31:0] pulse_tmr_ff, nxt_pulse_tmr;
  logic [NUM_CHAN-1:0] stat_ff, nxt_stat;
  logic nxt_alert;
  logic alert_hold_ff, nxt_alert_hold;
  logic done_ff, nxt_done;
  logic [3:0] done_ch_ff, nxt_done_ch;
  logic [31:0] conv_len;
  logic [3:0] ch_next;

  assign conv_len = (ch_ff == CH_REMOTE1 || ch_ff == CH_AMBIENT || ch_ff == CH_REMOTE2) ?
                    TEMP_CONV_CYCLES : VOLT_CONV_CYCLES;
  assign ch_next = (ch_ff + 4'h1 == CH_12V && cfg_ff[CFG_VID4_SEL_BIT]) ? CH_12V + 4'h1 : ch_ff + 4'h1;

  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_vc_reg = vc_reg_ff;
    nxt_sf = sf_ff;
    nxt_mst = mst_ff;
    nxt_ch = ch_ff;
    nxt_avg = avg_ff;
    nxt_conv_tmr = conv_tmr_ff;
    nxt_per_tmr = per_tmr_ff + 32'h1;
    nxt_pulse_tmr = (pulse_tmr_ff != 32'h0) ? pulse_tmr_ff - 32'h1 : 32'h0;
    nxt_stat = stat_ff;
    nxt_alert = alert_ff;
    nxt_alert_hold = alert_hold_ff;
    nxt_done = 1'b0;
    nxt_done_ch = done_ch_ff;
    // The pulse starts one cycle after the write, in the same cycle as the request bit drops.
    if (cfg_ff[CFG_RST_PULSE_BIT]) begin
      nxt_cfg[CFG_RST_PULSE_BIT] = 1'b0;
      if (vc_reg_ff[VC_RST_EN_BIT]) begin
        nxt_pulse_tmr = RST_PULSE_CYCLES;
      end
    end
    unique case (mst_ff)
      M_IDLE: begin
        if (cfg_ff[CFG_START_BIT]) begin
          nxt_mst = M_CONV;
          nxt_ch = CH_REMOTE1;
          nxt_avg = 8'h00;
          nxt_conv_tmr = 32'h0;
          nxt_per_tmr = 32'h0;
        end
      end
      M_CONV: begin
        nxt_conv_tmr = conv_tmr_ff + 32'h1;
        if (conv_tmr_ff + 32'h1 >= conv_len) begin
          nxt_conv_tmr = 32'h0;
          nxt_avg = avg_ff + 8'h1;
          if (avg_ff + 8'h1 >= avg_count(ch_ff, sf_ff[SF_FAST_AVG_BIT])) begin
            nxt_avg = 8'h00;
            nxt_done = 1'b1;
            nxt_done_ch = ch_ff;
            nxt_stat[ch_ff] = limit_fault_i[ch_ff];
            if (limit_fault_i[ch_ff] && !alert_hold_ff && cfg_ff[CFG_ALERT_EN_BIT]
                && !vc_reg_ff[VC_RST_EN_BIT]) begin
              nxt_alert = 1'b1;
            end
            if (ch_ff == CH_LAST) begin
              nxt_alert_hold = 1'b0;
              nxt_ch = CH_REMOTE1;
              nxt_mst = sf_ff[SF_CYCLE_MODE_BIT] ? M_WAIT : M_CONV;
              if (!sf_ff[SF_CYCLE_MODE_BIT]) begin
                nxt_per_tmr = 32'h0;
              end
            end else begin
              nxt_ch = ch_next;
            end
          end
        end
      end
      M_WAIT: begin
        if (per_tmr_ff + 32'h1 >= CYCLE_PERIOD_CYCLES) begin
          nxt_mst = M_CONV;
          nxt_per_tmr = 32'h0;
        end
      end
      default: nxt_mst = M_IDLE;
    endcase
    // Clearing the start bit stops the sequencer; status keeps its last value.
    if (!cfg_ff[CFG_START_BIT]) begin
      nxt_mst = M_IDLE;
    end
    if (ara_stb_ff) begin
      nxt_alert = 1'b0;
      nxt_alert_hold = 1'b1;
    end
    if (wr_stb_ff) begin
      unique case (ptr_ff)
        REG_CONFIG: begin
          nxt_cfg = wdata_ff;
          nxt_cfg[CFG_SOFT_RST_BIT] = 1'b0;
        end
        REG_VOLT_CODE: nxt_vc_reg[VC_RST_EN_BIT] = wdata_ff[VC_RST_EN_BIT];
        default: nxt_sf = wdata_ff;
      endcase
      if (ptr_ff == REG_CONFIG && wdata_ff[CFG_SOFT_RST_BIT]) begin
        nxt_cfg = CONFIG_RESET;
        nxt_vc_reg = {VOLT_RST_EN_RESET, 7'h00};
        nxt_sf = SPECIAL_RESET;
        nxt_stat = '0;
        nxt_alert = 1'b0;
        nxt_alert_hold = 1'b0;
        nxt_mst = M_IDLE;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_ff <= CONFIG_RESET;
      vc_reg_ff <= {VOLT_RST_EN_RESET, 7'h00};
      sf_ff <= SPECIAL_RESET;
      mst_ff <= M_IDLE;
      ch_ff <= CH_REMOTE1;
      avg_ff <= 8'h00;
      conv_tmr_ff <= 32'h0;
      per_tmr_ff <= 32'h0;
      pulse_tmr_ff <= 32'h0;
      stat_ff <= '0;
      alert_ff <= 1'b0;
      alert_hold_ff <= 1'b0;
      done_ff <= 1'b0;
      done_ch_ff <= 4'h0;
    end else begin
      cfg_ff <= nxt_cfg;
      vc_reg_ff <= nxt_vc_reg;
      sf_ff <= nxt_sf;
      mst_ff <= nxt_mst;
      ch_ff <= nxt_ch;
      avg_ff <= nxt_avg;
      conv_tmr_ff <= nxt_conv_tmr;
      per_tmr_ff <= nxt_per_tmr;
      pulse_tmr_ff <= nxt_pulse_tmr;
      stat_ff <= nxt_stat;
      alert_ff <= nxt_alert;
      alert_hold_ff <= nxt_alert_hold;
      done_ff <= nxt_done;
      done_ch_ff <= nxt_done_ch;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // The clock line is never driven, so this slave cannot stretch it.
  assign sda_o = 1'b0;
  assign sda_oe_o = drv_ff;
  assign addr_lsb_select_pin_o = 1'b0;
  // The shared pin stays released until the strap is caught, so it cannot corrupt the address.
  assign addr_lsb_select_pin_oe_o = strap_done_ff && ((pulse_tmr_ff != 32'h0) || alert_ff);
  assign conv_done_o = done_ff;
  assign conv_chan_o = done_ch_ff;
  assign int_status_o = stat_ff;
  assign monitor_busy_o = (mst_ff != M_IDLE);

endmodule

// *** sim/smm_monitor.sv ***
// Port assertions for the monitor's serial slave and its sequencer.
// Assumes one core clock domain with an active-low asynchronous reset.
`timescale 1ns/1ns
module smm_monitor import smm_pkg::*; #(
  parameter int unsigned VOLT_CONV_CYCLES = 3
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Watched ports
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic [NUM_CHAN-1:0] limit_fault_i,
  input wire logic conv_done_o,
  input wire logic [3:0] conv_chan_o,
  input wire logic [NUM_CHAN-1:0] int_status_o,
  input wire logic monitor_busy_o
);
  // ---------------------------------------------------------------------------
  // Cycles since the last finished conversion
  // ---------------------------------------------------------------------------
  logic [15:0] gap_ff;
  logic [15:0] nxt_gap;
  always_comb begin
    nxt_gap = conv_done_o ? 16'h0001 : gap_ff + {15'h0000, ~&gap_ff};
  end
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gap_ff <= 16'hFFFF;
    end else begin
      gap_ff <= nxt_gap;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i) && !$past(scl_i, 2))
    else $error("data line drive changed while the clock was not low");
  a_no_timeout: assert property ((!scl_i)[*7] |-> $stable(sda_oe_o))
    else $error("data line drive changed during a long clock low");
  a_reset_idle: assert property ($rose(rstn_i) |-> !sda_oe_o && !conv_done_o && !monitor_busy_o && int_status_o == '0)
    else $error("outputs not at defaults after reset");
  a_od_low: assert property (sda_oe_o |-> !sda_o)
    else $error("data line driven high");
  a_done_busy: assert property (conv_done_o |-> monitor_busy_o || $past(monitor_busy_o))
    else $error("conversion finished while sequencer idle");
  a_done_pulse: assert property (conv_done_o |=> !conv_done_o)
    else $error("conversion done longer than one cycle");
  a_chan_range: assert property (conv_done_o |-> conv_chan_o <= CH_LAST)
    else $error("conversion channel out of range");
  a_status_fault: assert property (conv_done_o |-> ##[0:2] int_status_o[conv_chan_o] == limit_fault_i[conv_chan_o])
    else $error("status flag does not follow the channel fault");
  a_conv_gap: assert property (conv_done_o |-> gap_ff >= 16'(VOLT_CONV_CYCLES))
    else $error("conversion shorter than one voltage conversion");
endmodule

// *** sim/smm_host_model.sv ***
// Behavioural bus master that clocks the serial link and pulls the data line.
// Assumes the bench resolves the pulled-up data wire and returns it on sda_i.
`timescale 1ns/1ns
module smm_host_model (
  // Bus lines
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  int stall_ns = 0;
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // ---------------------------------------------------------------------------
  // Bit slots of 125 ns; data moves while the clock is low, except in start and stop
  // ---------------------------------------------------------------------------
  task automatic bit_x(input logic b, output logic r);
    scl_o = 1'b0;
    #(20 + stall_ns);
    stall_ns = 0;
    sda_oe_o = ~b;
    #43;
    scl_o = 1'b1;
    #31;
    r = sda_i;
    #31;
  endtask
  task automatic start_c();
    logic r;
    bit_x(1'b1, r);
    sda_oe_o = 1'b1;
    #31;
  endtask
  task automatic stop_c();
    logic r;
    bit_x(1'b0, r);
    sda_oe_o = 1'b0;
    #31;
  endtask
  task automatic put_b(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(v[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  task automatic get_b(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(nack, r);
  endtask
endmodule

// *** sim/smm_slave_ctrl_bench.sv ***
// Self-checking bench for the monitor slave, its registers and shared pin.
// Assumes the host model carries all serial traffic; core clock is 100 MHz.
`timescale 1ns/1ns
module smm_slave_ctrl_bench import smm_pkg::*; ;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic scl, host_oe, dut_oe, pin_oe, pin_out, done, busy, strap, ext_lvl, m_rsten;
  logic [3:0] code, chan;
  logic [6:0] dev;
  logic [7:0] m_cfg, m_sf;
  logic [NUM_CHAN-1:0] fault, status;
  int seed = 32'h77F0E34E;
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  wire sda_w = ~(dut_oe | host_oe);
  wire pin_w = pin_oe ? pin_out : ext_lvl;

  smm_slave_ctrl #(.TEMP_CONV_CYCLES(4), .VOLT_CONV_CYCLES(3), .RST_PULSE_CYCLES(50),
    .CYCLE_PERIOD_CYCLES(2000)) i_dut (
    .mclk_i(mclk), .rstn_i(rstn), .scl_i(scl), .sda_i(sda_w), .sda_o(), .sda_oe_o(dut_oe),
    .addr_lsb_select_pin_i(pin_w), .addr_lsb_select_pin_o(pin_out), .addr_lsb_select_pin_oe_o(pin_oe),
    .cpu_volt_code_i(code), .limit_fault_i(fault), .conv_done_o(done), .conv_chan_o(chan),
    .int_status_o(status), .monitor_busy_o(busy));
  smm_host_model i_host (.sda_i(sda_w), .scl_o(scl), .sda_oe_o(host_oe));

  initial begin
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      give_verdict();
    end
  end
  // ---------------------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  function automatic logic [7:0] exp_reg(input logic [7:0] a);
    case (a)
      REG_CONFIG: exp_reg = m_cfg;
      REG_VOLT_CODE: exp_reg = {m_rsten, 3'h0, code};
      default: exp_reg = m_sf;
    endcase
  endfunction
  task automatic open(input logic [7:0] b, output logic k);
    i_host.start_c();
    i_host.put_b(b, k);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic k1, k2, k3;
    open({dev, 1'b0}, k1);
    i_host.put_b(a, k2);
    i_host.put_b(v, k3);
    i_host.stop_c();
    check("write acks", {k1, k2, k3}, 3'h7);
  endtask
  task automatic rd(input logic [7:0] a, input logic rcv);
    logic k1, k2, k3;
    logic [7:0] d;
    k1 = 1'b1;
    k2 = 1'b1;
    if (!rcv) begin
      open({dev, 1'b0}, k1);
      i_host.put_b(a, k2);
      if (rcv === 1'b0 && a === 8'hFF) i_host.stop_c();
    end
    open({dev, 1'b1}, k3);
    i_host.get_b(1'b1, d);
    i_host.stop_c();
    check("read acks", {k1, k2, k3}, 3'h7);
    check("read data", d, exp_reg(a));
  endtask
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    logic k, k2;
    logic [7:0] d;
    logic [7:0] vals [4];
    logic [7:0] bad [3];
    int n;
    strap = 1'($random(seed));
    ext_lvl = strap;
    code = 4'($random(seed));
    fault = '0;
    {m_cfg, m_sf, m_rsten} = 17'h00000;
    dev = {SLAVE_ADDR_HI, strap};
    repeat (12) @(posedge mclk);
    @(negedge mclk) rstn = 1'b1;
    repeat (8) @(negedge mclk);
    ext_lvl = ~strap;
    rd(REG_CONFIG, 1'b1);
    rd(REG_VOLT_CODE, 1'b0);
    rd(REG_SPECIAL, 1'b0);
    vals = '{8'($random(seed)), 8'h22, 8'h02, 8'h20};
    foreach (vals[i]) begin
      wr(REG_SPECIAL, vals[i]);
      m_sf = vals[i];
      rd(REG_SPECIAL, 1'b0);
    end
    open({dev, 1'b0}, k);
    i_host.put_b(REG_VOLT_CODE, k2);
    i_host.stop_c();
    check("pointer acks", {k, k2}, 2'h3);
    rd(REG_VOLT_CODE, 1'b1);
    rd(REG_VOLT_CODE, 1'b1);
    rd(REG_SPECIAL, 1'b0);
    bad = '{{dev[6:1], ~dev[0], 1'b0}, 8'h00, {ALERT_RESP_ADDR, 1'b1}};
    foreach (bad[i]) begin
      open(bad[i], k);
      i_host.stop_c();
      check("refused address", k, 1'b0);
    end
    open({dev, 1'b0}, k);
    i_host.put_b(8'h41, k);
    i_host.put_b(8'h55, k2);
    i_host.stop_c();
    check("bad register", {k, k2}, 2'h0);
    for (n = 0; n < 2; n++) begin
      open({dev, 1'b0}, k);
      i_host.put_b(REG_SPECIAL, k);
      i_host.put_b(~m_sf, k);
      if (n == 0) i_host.start_c();
      else i_host.put_b(8'h5A, k);
      i_host.stop_c();
      rd(REG_SPECIAL, 1'b0);
    end
    check("extra byte", k, 1'b0);
    open({dev, 1'b0}, k);
    i_host.stall_ns = 30000;
    i_host.put_b(REG_SPECIAL, k2);
    i_host.put_b(8'h00, d[0]);
    i_host.stop_c();
    check("stalled write acks", {k, k2, d[0]}, 3'h7);
    m_sf = 8'h00;
    rd(REG_SPECIAL, 1'b0);
    @(negedge mclk) fault = 11'($random(seed)) & 11'h3FF | 11'h001;
    wr(REG_CONFIG, 8'h03);
    for (n = 0; n < 3000 && pin_oe !== 1'b1; n++) @(negedge mclk);
    check("alert raised", pin_oe, 1'b1);
    open({ALERT_RESP_ADDR, 1'b1}, k);
    i_host.get_b(1'b1, d);
    i_host.stop_c();
    check("alert reply", {k, d}, {1'b1, dev, 1'b1});
    k2 = 1'b0;
    for (n = 0; n < 3000 && !(done === 1'b1 && chan === CH_LAST); n++) begin
      @(negedge mclk);
      k2 = k2 | pin_oe;
    end
    check("alert released", k2, 1'b0);
    for (n = 0; n < 1000 && pin_oe !== 1'b1; n++) @(negedge mclk);
    check("alert again", pin_oe, 1'b1);
    check("status", status, fault);
    wr(REG_SPECIAL, 8'h20);
    wr(REG_CONFIG, 8'h21);
    for (n = 0; n < 3000 && !(done === 1'b1 && chan === CH_12V - 4'h1); n++) @(negedge mclk);
    @(negedge mclk);
    for (n = 1; n < 100 && done !== 1'b1; n++) @(negedge mclk);
    check("12V skipped", chan, CH_12V + 4'h1);
    check("fast average", 16'(n), 16'(3 * AVG_OTHER_FAST));
    wr(REG_SPECIAL, 8'hA5);
    wr(REG_CONFIG, 8'h80);
    {m_cfg, m_sf} = 16'h0000;
    rd(REG_CONFIG, 1'b0);
    rd(REG_SPECIAL, 1'b0);
    check("stopped", {busy, status}, 12'h000);
    wr(REG_VOLT_CODE, 8'hFF);
    m_rsten = 1'b1;
    wr(REG_CONFIG, 8'h10);
    for (n = 0; n < 50 && pin_oe !== 1'b1; n++) @(negedge mclk);
    for (n = 0; n < 1000 && pin_oe === 1'b1; n++) @(negedge mclk);
    check("pulse length", 16'(n), 16'(50));
    rd(REG_CONFIG, 1'b0);
    rd(REG_VOLT_CODE, 1'b0);
    give_verdict();
  end
endmodule

bind smm_slave_ctrl smm_monitor #(.VOLT_CONV_CYCLES(VOLT_CONV_CYCLES)) i_mon (.mclk_i, .rstn_i, .scl_i,
  .sda_o, .sda_oe_o, .limit_fault_i, .conv_done_o, .conv_chan_o, .int_status_o, .monitor_busy_o);
